// >>> src/sadc_top.v
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`include "sadc_map.vh"
// ****************************************************
// converter control with AHB-Lite register slave
// ****************************************************
module sadc_top #(
  parameter RES_W = `SADC_RES_BITS
) (
  // clock, reset, enable
  input wire clk,
  input wire rst_b,
  input wire ce,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire [31:0] hrdata,
  output wire hresp,
  // start sources and chip sleep
  input wire timer3_ovf,
  input wire timer2_ovf,
  input wire external_convert_start,
  input wire chip_sleep,
  // analog side
  input wire cmp_hi,
  output wire analog_enable,
  output wire track,
  output wire [RES_W-1:0] sar_trial,
  output wire [5:0] gain_onehot,
  output wire [2:0] mux_pos_ch,
  output wire [2:0] mux_neg_ch,
  output wire mux_diff,
  output wire mux_temp,
  // status
  output wire conversion_busy_bit,
  output wire conversion_done_flag
);
  // ****************************************************
  // reset and pin synchronisers
  // ****************************************************
  reg [1:0] rst_sync_ff; // reset release pipeline
  wire rst_n = rst_sync_ff[1];
  reg ext_s1_ff; // first stage, read only by second
  reg ext_s2_ff;
  reg ext_prev_ff; // for edge detection
  reg cmp_s1_ff; // first stage, read only by second
  reg cmp_s2_ff;

  // reset asserts at once, releases after two edges
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  // both pins come from outside the clock domain
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1_ff <= 1'b0;
      ext_s2_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
      cmp_s1_ff <= 1'b0;
      cmp_s2_ff <= 1'b0;
    end else if (ce) begin
      ext_s1_ff <= external_convert_start;
      ext_s2_ff <= ext_s1_ff;
      ext_prev_ff <= ext_s2_ff;
      cmp_s1_ff <= cmp_hi;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  // ****************************************************
  // registers and bus state
  // ****************************************************
  reg [7:0] converter_control_reg_ff; // bit4 unused, busy comes from sequencer
  reg [7:0] converter_config_reg_ff;
  reg [3:0] channel_select_reg_ff;
  reg [3:0] pair_config_reg_ff;
  // sized copies of the reset values so their low nibble can be taken
  localparam [7:0] CHSEL_RST = `SADC_CHSEL_RST;
  localparam [7:0] PAIR_RST = `SADC_PAIR_RST;
  reg wr_pend_ff; // write data phase pending
  reg rd_pend_ff; // read wait state pending
  reg [7:0] dp_idx_ff; // index of data phase
  reg dp_hit_ff; // address inside register window
  reg hreadyout_ff;
  reg [31:0] hrdata_ff;

  wire busy; // sequencer busy
  wire in_track;
  wire conv_done;
  wire [RES_W-1:0] trial;
  wire [RES_W-1:0] result;
  wire sar_tick;

  wire en = converter_control_reg_ff[`SADC_CTRL_EN];
  wire tm = converter_control_reg_ff[`SADC_CTRL_TM];
  wire [1:0] cm = converter_control_reg_ff[`SADC_CTRL_CM_HI:`SADC_CTRL_CM_LO];
  wire lj = converter_control_reg_ff[`SADC_CTRL_LJ];
  wire [2:0] gain = converter_config_reg_ff[`SADC_CFG_GAIN_HI:`SADC_CFG_GAIN_LO];
  wire [4:0] div = converter_config_reg_ff[`SADC_CFG_DIV_HI:`SADC_CFG_DIV_LO];
  wire ext_mode = (cm == `SADC_CM_EXT);

  // address phase accepted only when the bus is ready
  wire ap_take = hsel & hready & htrans[1];
  wire ctrl_wr = wr_pend_ff & dp_hit_ff & (dp_idx_ff == `SADC_CTRL_IDX);

  // ****************************************************
  // start sources
  // ****************************************************
  reg start_now; // start event this cycle

  // select one source by start mode
  always @* begin
    start_now = 1'b0;
    case (cm)
      `SADC_CM_SW: start_now = ctrl_wr & hwdata[`SADC_CTRL_BUSY];
      `SADC_CM_TMR3: start_now = timer3_ovf;
      `SADC_CM_EXT: start_now = ext_s2_ff & ~ext_prev_ff;
      `SADC_CM_TMR2: start_now = timer2_ovf;
      default: start_now = 1'b0;
    endcase
  end

  // in external mode the pin low time is the tracking, so no extra clocks
  wire pre_track = tm & ~ext_mode;

  // ****************************************************
  // conversion clock and sequencer
  // ****************************************************
  sadc_clkdiv #(
    .DIV_W(5)
  ) u_clkdiv (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    // restart per conversion: a free phase could tick before the comparator settles
    .run(en & (busy | start_now)),
    .div(div),
    .tick(sar_tick)
  );

  sadc_conv #(
    .RES_W(RES_W),
    .TRK_CLKS(`SADC_TRACK_CLKS)
  ) u_conv (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .enable(en),
    .start(start_now & en),
    .pre_track(pre_track),
    .sar_tick(sar_tick),
    .cmp_hi(cmp_s2_ff),
    .busy(busy),
    .in_track(in_track),
    .done(conv_done),
    .trial(trial),
    .result(result)
  );

  // ****************************************************
  // register writes
  // ****************************************************
  // done flag: hardware set wins over a software write in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_control_reg_ff <= `SADC_CTRL_RST;
      converter_config_reg_ff <= `SADC_CFG_RST;
      channel_select_reg_ff <= CHSEL_RST[3:0];
      pair_config_reg_ff <= PAIR_RST[3:0];
    end else if (ce) begin
      if (wr_pend_ff & dp_hit_ff) begin
        case (dp_idx_ff)
          `SADC_CTRL_IDX: converter_control_reg_ff <= {hwdata[7:5], 1'b0, hwdata[3:0]};
          `SADC_CFG_IDX: converter_config_reg_ff <= hwdata[7:0];
          `SADC_CHSEL_IDX: channel_select_reg_ff <= hwdata[3:0];
          `SADC_PAIR_IDX: pair_config_reg_ff <= hwdata[3:0];
          default: converter_control_reg_ff <= converter_control_reg_ff;
        endcase
      end
      if (conv_done) begin
        converter_control_reg_ff[`SADC_CTRL_DONE] <= 1'b1;
      end
    end
  end

  // ****************************************************
  // read mux
  // ****************************************************
  reg [15:0] just; // justified result
  reg [31:0] rd_val;

  // justification is applied on read, so flipping the bit reformats old data
  always @* begin
    just = lj ? {result, 4'h0} : {4'h0, result};
    rd_val = 32'h0000_0000;
    if (dp_hit_ff) begin
      case (dp_idx_ff)
        `SADC_CTRL_IDX: rd_val = {24'h00_0000, converter_control_reg_ff[7:5], busy,
                                  converter_control_reg_ff[3:0]};
        `SADC_CFG_IDX: rd_val = {24'h00_0000, converter_config_reg_ff};
        `SADC_CHSEL_IDX: rd_val = {28'h000_0000, channel_select_reg_ff};
        `SADC_PAIR_IDX: rd_val = {28'h000_0000, pair_config_reg_ff};
        `SADC_RESH_IDX: rd_val = {24'h00_0000, just[15:8]};
        `SADC_RESL_IDX: rd_val = {24'h00_0000, just[7:0]};
        default: rd_val = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************
  // ahb-lite slave: writes zero wait, reads one wait state
  // ****************************************************
  // the read wait lets a write in the preceding data phase land first
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      dp_idx_ff <= 8'h00;
      dp_hit_ff <= 1'b0;
      hreadyout_ff <= 1'b1;
      hrdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      if (rd_pend_ff) begin
        rd_pend_ff <= 1'b0;
        hreadyout_ff <= 1'b1;
        hrdata_ff <= rd_val;
      end else if (hreadyout_ff) begin
        wr_pend_ff <= ap_take & hwrite;
        rd_pend_ff <= ap_take & ~hwrite;
        hreadyout_ff <= ~(ap_take & ~hwrite);
        if (ap_take) begin
          dp_idx_ff <= haddr[9:2];
          dp_hit_ff <= (haddr[31:10] == 22'h00_0000) & (haddr[1:0] == 2'h0);
        end
      end
    end
  end

  // ****************************************************
  // analog controls, all registered
  // ****************************************************
  reg analog_enable_ff;
  reg track_ff;
  reg [5:0] gain_onehot_ff;
  reg [2:0] mux_pos_ff;
  reg [2:0] mux_neg_ff;
  reg mux_diff_ff;
  reg mux_temp_ff;
  reg [5:0] nxt_gain;
  reg nxt_diff;

  // gain decode; x1 at reset, top code bits pick x16 or x0.5
  always @* begin
    case (gain)
      3'h0: nxt_gain = 6'h01;
      3'h1: nxt_gain = 6'h02;
      3'h2: nxt_gain = 6'h04;
      3'h3: nxt_gain = 6'h08;
      3'h4, 3'h5: nxt_gain = 6'h10;
      3'h6, 3'h7: nxt_gain = 6'h20;
      default: nxt_gain = 6'h01;
    endcase
    nxt_diff = ~channel_select_reg_ff[3] & pair_config_reg_ff[channel_select_reg_ff[2:1]];
  end

  // odd member of a differential pair selects the same pair
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_enable_ff <= 1'b0;
      track_ff <= 1'b0;
      gain_onehot_ff <= 6'h01;
      mux_pos_ff <= 3'h0;
      mux_neg_ff <= 3'h0;
      mux_diff_ff <= 1'b0;
      mux_temp_ff <= 1'b0;
    end else if (ce) begin
      analog_enable_ff <= en;
      track_ff <= en & ~chip_sleep & (in_track |
                  (~busy & (~tm | (ext_mode & ~ext_s2_ff))));
      gain_onehot_ff <= nxt_gain;
      mux_temp_ff <= channel_select_reg_ff[3];
      mux_diff_ff <= nxt_diff;
      mux_pos_ff <= nxt_diff ? {channel_select_reg_ff[2:1], 1'b0} : channel_select_reg_ff[2:0];
      mux_neg_ff <= nxt_diff ? {channel_select_reg_ff[2:1], 1'b1} : 3'h0;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign hreadyout = hreadyout_ff;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;
  assign analog_enable = analog_enable_ff;
  assign track = track_ff;
  assign sar_trial = trial;
  assign gain_onehot = gain_onehot_ff;
  assign mux_pos_ch = mux_pos_ff;
  assign mux_neg_ch = mux_neg_ff;
  assign mux_diff = mux_diff_ff;
  assign mux_temp = mux_temp_ff;
  assign conversion_busy_bit = busy;
  assign conversion_done_flag = converter_control_reg_ff[`SADC_CTRL_DONE];
endmodule

// >>> src/sadc_map.vh
`ifndef SADC_MAP_VH
`define SADC_MAP_VH

// ****************************************************
// register indices, byte address is four times index
// ****************************************************
`define SADC_PAIR_IDX 8'hba
`define SADC_CHSEL_IDX 8'hbb
`define SADC_CFG_IDX 8'hbc
`define SADC_RESH_IDX 8'hbe
`define SADC_RESL_IDX 8'hbf
`define SADC_CTRL_IDX 8'he8

// ****************************************************
// reset values
// ****************************************************
`define SADC_CTRL_RST 8'h00
`define SADC_CFG_RST 8'hf8
`define SADC_CHSEL_RST 8'h00
`define SADC_PAIR_RST 8'h00

// ****************************************************
// control register fields
// ****************************************************
`define SADC_CTRL_EN 7
`define SADC_CTRL_TM 6
`define SADC_CTRL_DONE 5
`define SADC_CTRL_BUSY 4
`define SADC_CTRL_CM_HI 3
`define SADC_CTRL_CM_LO 2
`define SADC_CTRL_WIN 1
`define SADC_CTRL_LJ 0

// ****************************************************
// config register fields and start modes
// ****************************************************
`define SADC_CFG_DIV_HI 7
`define SADC_CFG_DIV_LO 3
`define SADC_CFG_GAIN_HI 2
`define SADC_CFG_GAIN_LO 0
`define SADC_CM_SW 2'h0
`define SADC_CM_TMR3 2'h1
`define SADC_CM_EXT 2'h2
`define SADC_CM_TMR2 2'h3

// ****************************************************
// timing
// ****************************************************
`define SADC_TRACK_CLKS 3
`define SADC_RES_BITS 12

`endif

// >>> src/sadc_clkdiv.v
`timescale 1ns/10ps
// ****************************************************
// conversion clock divider: one tick per 2*(div+1) cycles
// ****************************************************
module sadc_clkdiv #(
  parameter DIV_W = 5
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // control
  input wire run,
  input wire [DIV_W-1:0] div,
  // tick out
  output reg tick
);
  reg [DIV_W:0] cnt_ff; // counts both half periods
  wire [DIV_W:0] last = {div, 1'b1};

  // counter held at zero while idle so the first tick is a full period
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= {(DIV_W+1){1'b0}};
      tick <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_ff <= {(DIV_W+1){1'b0}};
        tick <= 1'b0;
      end else if (cnt_ff == last) begin
        cnt_ff <= {(DIV_W+1){1'b0}};
        tick <= 1'b1;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
        tick <= 1'b0;
      end
    end
  end
endmodule

// >>> src/sadc_conv.v
`timescale 1ns/10ps
`include "sadc_map.vh"
// ****************************************************
// successive approximation sequencer
// ****************************************************
module sadc_conv #(
  parameter RES_W = `SADC_RES_BITS,
  parameter TRK_CLKS = `SADC_TRACK_CLKS
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire ce,
  // control
  input wire enable,
  input wire start,
  input wire pre_track,
  input wire sar_tick,
  input wire cmp_hi,
  // status
  output reg busy,
  output reg in_track,
  output reg done,
  output reg [RES_W-1:0] trial,
  output reg [RES_W-1:0] result
);
  localparam ST_IDLE = 3'b001;
  localparam ST_TRACK = 3'b010;
  localparam ST_CONV = 3'b100;

  reg [2:0] st_ff; // one-hot state
  reg [1:0] trk_ff; // tracking clocks left
  reg [RES_W-1:0] mask_ff; // bit under trial
  wire [RES_W-1:0] kept = cmp_hi ? trial : (trial & ~mask_ff);
  wire [RES_W-1:0] top_bit = {1'b1, {(RES_W-1){1'b0}}};

  // state machine; disabling aborts without a done pulse
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_IDLE;
      trk_ff <= 2'h0;
      mask_ff <= {RES_W{1'b0}};
      trial <= {RES_W{1'b0}};
      result <= {RES_W{1'b0}};
      busy <= 1'b0;
      in_track <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (!enable) begin
        st_ff <= ST_IDLE;
        busy <= 1'b0;
        in_track <= 1'b0;
      end else begin
        case (st_ff)
          ST_IDLE: begin
            // a start is only looked at here, so starts while busy vanish
            if (start) begin
              busy <= 1'b1;
              if (pre_track) begin
                st_ff <= ST_TRACK;
                in_track <= 1'b1;
                trk_ff <= TRK_CLKS[1:0];
              end else begin
                st_ff <= ST_CONV;
                mask_ff <= top_bit;
                trial <= top_bit;
              end
            end
          end
          ST_TRACK: begin
            if (sar_tick) begin
              if (trk_ff == 2'h1) begin
                st_ff <= ST_CONV;
                in_track <= 1'b0;
                mask_ff <= top_bit;
                trial <= top_bit;
              end else begin
                trk_ff <= trk_ff - 2'h1;
              end
            end
          end
          ST_CONV: begin
            if (sar_tick) begin
              trial <= kept | (mask_ff >> 1);
              mask_ff <= mask_ff >> 1;
              if (mask_ff[0]) begin
                result <= kept;
                busy <= 1'b0;
                done <= 1'b1;
                st_ff <= ST_IDLE;
              end
            end
          end
          default: begin
            st_ff <= ST_IDLE;
            busy <= 1'b0;
            in_track <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// >>> testbench/sadc_analog_model.sv
`timescale 1ns/10ps
// ****************************************************
// far side: held analog input and start pin
// ****************************************************
module sadc_analog_model (
  // clock, commands from the bench and from the block
  input wire clk,
  input wire analog_enable,
  input wire ext_cmd,
  input wire [11:0] sar_trial,
  input wire [11:0] vin,
  // lines into the block
  output wire cmp_hi,
  output wire external_convert_start
);
  reg alt = 1'b0; // toggles so a powered-down comparator never looks settled
  always @(posedge clk) begin
    alt <= ~alt;
  end
  // comparator high while the held input is at or above the trial code
  assign cmp_hi = analog_enable ? (vin >= sar_trial) : alt;
  // pin follows the bench; its rising edge is the start event
  assign external_convert_start = ext_cmd;
endmodule

// >>> testbench/sadc_monitor.sv
`timescale 1ns/10ps
// ****************************************************
// port checker for the converter control
// ****************************************************
module sadc_monitor #(
  parameter RES_W = 12
) (
  // clock, reset, bus
  input wire clk, rst_b, ce, hsel, hwrite, hready, hreadyout, hresp,
  input wire [31:0] haddr, hwdata, hrdata,
  input wire [1:0] htrans,
  input wire [2:0] hsize,
  // start sources, chip sleep and analog side
  input wire timer3_ovf, timer2_ovf, external_convert_start, chip_sleep, cmp_hi,
  input wire analog_enable, track, mux_diff, mux_temp,
  input wire [RES_W-1:0] sar_trial,
  input wire [5:0] gain_onehot,
  input wire [2:0] mux_pos_ch, mux_neg_ch,
  // status
  input wire conversion_busy_bit, conversion_done_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_gain_onehot: assert property ($onehot(gain_onehot))
    else $error("gain select not one-hot");
  // an abort drops enable at once, so only a fall that stays enabled counts
  a_done_on_fall: assert property (
    ($fell(conversion_busy_bit) && analog_enable) ##1 analog_enable |-> conversion_done_flag)
    else $error("done flag not set after busy fell");
  a_busy_hold: assert property ($rose(conversion_busy_bit) |-> conversion_busy_bit[*8])
    else $error("busy too short");
  a_power_track: assert property (!analog_enable |-> !track)
    else $error("tracking while powered down");
  a_sleep_track: assert property (chip_sleep |=> !track)
    else $error("tracking during chip sleep");
  a_single_neg: assert property (!mux_diff |-> mux_neg_ch == 3'h0)
    else $error("negative input set in single-ended");
  a_diff_pair: assert property (
    mux_diff |-> !mux_pos_ch[0] && mux_neg_ch == mux_pos_ch + 3'h1)
    else $error("differential pair not adjacent");
  a_temp_single: assert property (mux_temp |-> !mux_diff)
    else $error("sensor routed as pair");
  a_read_wait: assert property (
    hsel && hready && htrans[1] && !hwrite && ce |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  c_conv_end: cover property ($fell(conversion_busy_bit));
  c_diff: cover property (mux_diff);
  c_temp: cover property (mux_temp);
endmodule

// >>> testbench/tb_sadc_top.sv
`timescale 1ns/10ps
`include "sadc_map.vh"
// ****************************************************
// self-checking bench for the converter control
// ****************************************************
module tb_sadc_top;
  localparam [31:0] A_CTRL = `SADC_CTRL_IDX * 4;
  localparam [31:0] A_CFG = `SADC_CFG_IDX * 4;
  localparam [31:0] A_CHSEL = `SADC_CHSEL_IDX * 4;
  localparam [31:0] A_PAIR = `SADC_PAIR_IDX * 4;
  localparam [31:0] A_RESH = `SADC_RESH_IDX * 4;
  localparam [31:0] A_RESL = `SADC_RESL_IDX * 4;
  // bench drives, all set at time zero
  reg clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  reg t3 = 1'b0, t2 = 1'b0, sleep_r = 1'b0, ext_cmd = 1'b0, trk10 = 1'b0;
  reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd = 32'h0, ctrl = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg [11:0] vin = 12'h0;
  reg [15:0] mux_tab [0:3]; // pair, select, pos, neg, diff, temp
  wire hrdy, hresp, aen, trk, mdiff, mtemp, busy, done, cmp, pin;
  wire [31:0] hrdata;
  wire [11:0] trial;
  wire [5:0] gain;
  wire [2:0] mpos, mneg;
  integer mismatches = 0, n_checks = 0, len, i, m;
  sadc_top dut_u (.clk(clk), .rst_b(rst_b), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp), .timer3_ovf(t3), .timer2_ovf(t2),
    .external_convert_start(pin), .chip_sleep(sleep_r), .cmp_hi(cmp), .analog_enable(aen),
    .track(trk), .sar_trial(trial), .gain_onehot(gain), .mux_pos_ch(mpos),
    .mux_neg_ch(mneg), .mux_diff(mdiff), .mux_temp(mtemp), .conversion_busy_bit(busy),
    .conversion_done_flag(done));
  sadc_analog_model far_u (.clk(clk), .analog_enable(aen), .ext_cmd(ext_cmd),
    .sar_trial(trial), .vin(vin), .cmp_hi(cmp), .external_convert_start(pin));
  // single compare point
  task check(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // ahb-lite single transfers; both wait on hready, never on a fixed count
  task ahb_wr(input [31:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= 1'b1;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
    end
  endtask
  task ahb_rd(input [31:0] a, output [31:0] d);
    begin
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= 1'b0;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      d = hrdata;
    end
  endtask
  // start event: 0 software, 1 timer 3, 2 pin edge, 3 timer 2
  task fire(input integer src);
    begin
      if (src == 0) begin
        ahb_wr(A_CTRL, ctrl | 32'h10);
      end else if (src == 2) begin
        ext_cmd <= 1'b0;
        repeat (4) @(posedge clk);
        ext_cmd <= 1'b1;
        @(posedge clk);
      end else begin
        t3 <= (src == 1);
        t2 <= (src == 3);
        @(posedge clk);
        t3 <= 1'b0;
        t2 <= 1'b0;
        @(posedge clk);
      end
    end
  endtask
  // counts busy cycles; for a hardware source a second start mid-conversion must change nothing
  task measure(input integer src);
    integer n;
    begin
      n = 0;
      len = 0;
      while (busy !== 1'b1 && n < 50) begin
        @(posedge clk);
        n = n + 1;
      end
      while (busy === 1'b1 && len < 2000) begin
        if (len == 10) trk10 = trk;
        if (len == 100 && src != 0) fire(src);
        @(posedge clk);
        len = len + 1;
      end
    end
  endtask
  task final_report;
    begin
      $display("checks=%0d mismatches=%0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  // hang guard, well above the longest expected run
  initial begin
    repeat (30000) @(posedge clk);
    mismatches = mismatches + 1;
    final_report;
  end
  initial begin
    mux_tab[0] = {4'h0, 4'h3, 3'h3, 3'h0, 2'h0};
    mux_tab[1] = {4'h1, 4'h1, 3'h0, 3'h1, 2'h2};
    mux_tab[2] = {4'h8, 4'h6, 3'h6, 3'h7, 2'h2};
    mux_tab[3] = {4'h4, 4'h5, 3'h4, 3'h5, 2'h2};
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    ahb_rd(A_CTRL, rd);
    check(rd, 32'h0);
    ahb_rd(A_CFG, rd);
    check(rd, 32'hf8);
    ahb_rd(A_CHSEL, rd);
    check(rd, 32'h0);
    ahb_rd(A_PAIR, rd);
    check(rd, 32'h0);
    check(gain, 6'h01);
    check(aen, 1'b0);
    check(hresp, 1'b0);
    ahb_wr(32'h0, 32'hff);
    ahb_rd(32'h0, rd);
    check(rd, 32'h0);
    ahb_wr(A_PAIR, 32'hff);
    ahb_rd(A_PAIR, rd);
    check(rd, 32'h0f);
    for (i = 0; i < 8; i = i + 1) begin
      ahb_wr(A_CFG, 32'hf8 | i);
      repeat (2) @(posedge clk);
      check(gain, i[2] ? (i[1] ? 6'h20 : 6'h10) : (6'h01 << i[1:0]));
    end
    ahb_wr(A_CFG, 32'hf8); // slowest divider
    for (i = 0; i < 4; i = i + 1) begin
      ahb_wr(A_PAIR, 32'(mux_tab[i][15:12]));
      ahb_wr(A_CHSEL, 32'(mux_tab[i][11:8]));
      repeat (2) @(posedge clk);
      check({mpos, mneg, mdiff, mtemp}, 32'(mux_tab[i][7:0]));
    end
    ahb_wr(A_CHSEL, 32'h8);
    repeat (2) @(posedge clk);
    check({mdiff, mtemp}, 2'h1);
    ahb_wr(A_PAIR, 32'h0);
    ahb_wr(A_CHSEL, 32'h0);
    ahb_wr(A_CTRL, 32'h80);
    repeat (2) @(posedge clk);
    check(aen, 1'b1);
    check(trk, 1'b1);
    sleep_r <= 1'b1;
    repeat (2) @(posedge clk);
    check(trk, 1'b0);
    sleep_r <= 1'b0;
    repeat (300) @(posedge clk); // settle after sleep release
    for (i = 0; i < 2; i = i + 1) begin
      vin <= i ? 12'h5a3 : 12'habc;
      ctrl = i ? 32'h81 : 32'h80;
      ahb_wr(A_CTRL, ctrl); // clear done first
      fire(0);
      measure(0);
      check(len >= 698 && len <= 770, 1'b1);
      rd = 32'h0;
      for (m = 0; m < 20 && !rd[5]; m = m + 1) ahb_rd(A_CTRL, rd);
      check(rd[5], 1'b1);
      ahb_rd(A_RESH, rd);
      check(rd, i ? {24'h0, vin[11:4]} : {28'h0, vin[11:8]});
      ahb_rd(A_RESL, rd);
      check(rd, i ? {24'h0, vin[3:0], 4'h0} : {24'h0, vin[7:0]});
    end
    for (m = 1; m < 4; m = m + 1) begin
      ctrl = 32'h80 | (m << 2);
      ahb_wr(A_CTRL, ctrl);
      fire(m == 1 ? 3 : 1);
      repeat (8) @(posedge clk);
      check(busy, 1'b0);
      fire(m);
      measure(m);
      check(len >= 698 && len <= 770, 1'b1);
      @(posedge clk); // flag lands one edge after busy falls
      check(done, 1'b1);
    end
    ext_cmd <= 1'b0;
    ctrl = 32'hc0;
    ahb_wr(A_CTRL, ctrl);
    fire(0);
    measure(0);
    check(len >= 890 && len <= 962, 1'b1);
    check(trk10, 1'b1);
    ctrl = 32'hc8;
    ahb_wr(A_CTRL, ctrl);
    repeat (6) @(posedge clk);
    check(trk, 1'b1);
    fire(2);
    measure(0);
    check(len >= 698 && len <= 770, 1'b1);
    check(trk10, 1'b0);
    ctrl = 32'h80;
    ahb_wr(A_CTRL, ctrl);
    fire(0);
    repeat (20) @(posedge clk);
    ahb_wr(A_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    check({busy, done, aen, trk}, 4'h0);
    final_report;
  end
endmodule
bind sadc_top sadc_monitor #(.RES_W(RES_W)) mon_u (.*);
